/* hdl/srs_startup_ctrl.sv */
// Start-up and reset sequencer: shutdown pin, power-on reset, straps, soft reset.
// Supply comparators arrive as synchronous levels; pins are synchronous to clk.
`include "srs_params.svh"

// How it works
// - While the shutdown pin is low the device and its serial interface stay disabled.
// - A rising shutdown pin starts the power-on reset sequence, then normal operation.
// - Reset is held until all core supplies exceed 2.72 V and the pin exceeds 1.2 V.
// - The interface strap picks SPI when high and I2C when grounded at start-up.
// - The two three-level page straps choose which configuration page to load.
// - A soft reset after supplies settle reruns calibration and PLL start-up.
module srs_startup_ctrl #(
  parameter int POR_HOLD_CYC = `SRS_POR_HOLD_CYC,
  parameter int CAL_CYC      = `SRS_CAL_CYC
) (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                chip_shutdown_low,
  input  wire logic                core_supply_ok,
  input  wire logic                shutdown_pin_above_vih,
  input  wire logic                interface_select_strap,
  input  wire srs_pkg::srs_level_t rom_page_strap_a,
  input  wire srs_pkg::srs_level_t rom_page_strap_b,
  input  wire logic                soft_reset_bit,
  input  wire logic                output_sync_hold_bit,
  output logic                     device_enable,
  output logic                     serial_if_enable,
  output logic                     serial_if_spi,
  output logic [3:0]               rom_page_select,
  output logic                     config_load,
  output logic                     vco_cal_start,
  output logic                     outputs_released,
  output logic                     straps_as_gpio
);
  // ------------------------------------------------------------
  // Shutdown pin filter
  // ------------------------------------------------------------
  // Short lows are glitches; only a low of the full width resets
  localparam int FILT_W = $clog2(`SRS_PD_FILT_CYC + 1);
  localparam int POR_W  = $clog2(POR_HOLD_CYC + 1);
  localparam int CAL_W  = $clog2(CAL_CYC + 1);

  logic [FILT_W-1:0]   low_cnt_r, low_cnt_nxt;
  logic                pd_active_r, pd_active_nxt;

  always_comb begin
    low_cnt_nxt   = low_cnt_r;
    pd_active_nxt = pd_active_r;
    if (chip_shutdown_low) begin
      low_cnt_nxt   = '0;
      pd_active_nxt = 1'b0;
    end else if (low_cnt_r == FILT_W'(`SRS_PD_FILT_CYC)) begin
      pd_active_nxt = 1'b1;
    end else begin
      low_cnt_nxt = low_cnt_r + FILT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      low_cnt_r   <= '0;
      pd_active_r <= 1'b1;
    end else begin
      low_cnt_r   <= low_cnt_nxt;
      pd_active_r <= pd_active_nxt;
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  srs_pkg::srs_state_t st_r, st_nxt;
  logic [POR_W-1:0]    por_cnt_r, por_cnt_nxt;
  logic [CAL_W-1:0]    cal_cnt_r, cal_cnt_nxt;
  logic                soft_reset_bit_d_r, soft_reset_bit_d_nxt;
  logic                capture;
  logic                por_ok;
  logic                soft_reset_bit_rise;
  logic                in_service;

  // ------------------------------------------------------------
  // Strap capture
  // ------------------------------------------------------------
  srs_strap_if strap ();

  srs_strap_latch u_strap (
    .clk                    (clk),
    .reset_n                (reset_n),
    .capture                (capture),
    .interface_select_strap (interface_select_strap),
    .rom_page_strap_a       (rom_page_strap_a),
    .rom_page_strap_b       (rom_page_strap_b),
    .strap                  (strap)
  );

  assign por_ok     = core_supply_ok && shutdown_pin_above_vih;
  assign soft_reset_bit_rise = soft_reset_bit && !soft_reset_bit_d_r;
  assign capture    = (st_r == srs_pkg::SRS_STRAP_LATCH);
  // Calibrating or running: the straps of this start-up are latched
  assign in_service = (st_r == srs_pkg::SRS_CALIBRATE) || (st_r == srs_pkg::SRS_RUN);

  always_comb begin
    st_nxt      = st_r;
    por_cnt_nxt = por_cnt_r;
    cal_cnt_nxt = cal_cnt_r;
    soft_reset_bit_d_nxt = soft_reset_bit;
    if (pd_active_r) begin
      st_nxt      = srs_pkg::SRS_SHUTDOWN;
      por_cnt_nxt = '0;
      cal_cnt_nxt = '0;
    end else begin
      unique case (st_r)
        srs_pkg::SRS_SHUTDOWN: begin
          st_nxt      = srs_pkg::SRS_POR_HOLD;
          por_cnt_nxt = '0;
        end
        srs_pkg::SRS_POR_HOLD: begin
          if (!por_ok) begin
            por_cnt_nxt = '0;
          end else if (por_cnt_r == POR_W'(POR_HOLD_CYC)) begin
            st_nxt = srs_pkg::SRS_STRAP_LATCH;
          end else begin
            por_cnt_nxt = por_cnt_r + POR_W'(1);
          end
        end
        srs_pkg::SRS_STRAP_LATCH: begin
          st_nxt      = srs_pkg::SRS_CALIBRATE;
          cal_cnt_nxt = '0;
        end
        srs_pkg::SRS_CALIBRATE: begin
          if (cal_cnt_r == CAL_W'(CAL_CYC)) begin
            st_nxt = srs_pkg::SRS_RUN;
          end else begin
            cal_cnt_nxt = cal_cnt_r + CAL_W'(1);
          end
        end
        srs_pkg::SRS_RUN: begin
          // Soft reset reruns calibration but skips the strap capture
          if (soft_reset_bit_rise) begin
            st_nxt      = srs_pkg::SRS_CALIBRATE;
            cal_cnt_nxt = '0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_r      <= srs_pkg::SRS_SHUTDOWN;
      por_cnt_r <= '0;
      cal_cnt_r <= '0;
      soft_reset_bit_d_r <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      por_cnt_r <= por_cnt_nxt;
      cal_cnt_r <= cal_cnt_nxt;
      soft_reset_bit_d_r <= soft_reset_bit_d_nxt;
    end
  end

  // ------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------
  logic       dev_en_nxt;
  logic       ser_en_nxt;
  logic       spi_nxt;
  logic       load_nxt;
  logic       cal_nxt;
  logic       rel_nxt;
  logic       gpio_nxt;
  logic [3:0] page_nxt;
  logic       load_pend_r, load_pend_nxt;

  always_comb begin
    // Load pulse trails the capture so the page is settled
    load_pend_nxt = capture;
    dev_en_nxt    = (st_nxt == srs_pkg::SRS_CALIBRATE) || (st_nxt == srs_pkg::SRS_RUN);
    // Opens with the fresh strap choice, never while shut down;
    // valid alone would stay set from an earlier start-up
    ser_en_nxt    = !pd_active_nxt && strap.valid && in_service
                    && ((st_nxt == srs_pkg::SRS_CALIBRATE) || (st_nxt == srs_pkg::SRS_RUN));
    spi_nxt       = strap.interface_spi;
    page_nxt      = strap.rom_page;
    load_nxt      = load_pend_r;
    cal_nxt       = (st_r != srs_pkg::SRS_CALIBRATE) && (st_nxt == srs_pkg::SRS_CALIBRATE);
    // Outputs wait for calibration and for the host's sync hold to drop
    rel_nxt       = (st_nxt == srs_pkg::SRS_RUN) && !output_sync_hold_bit;
    gpio_nxt      = (st_nxt == srs_pkg::SRS_CALIBRATE) || (st_nxt == srs_pkg::SRS_RUN);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      load_pend_r      <= 1'b0;
      device_enable    <= 1'b0;
      serial_if_enable <= 1'b0;
      serial_if_spi    <= 1'b0;
      rom_page_select  <= 4'h0;
      config_load      <= 1'b0;
      vco_cal_start    <= 1'b0;
      outputs_released <= 1'b0;
      straps_as_gpio   <= 1'b0;
    end else begin
      load_pend_r      <= load_pend_nxt;
      device_enable    <= dev_en_nxt;
      serial_if_enable <= ser_en_nxt;
      serial_if_spi    <= spi_nxt;
      rom_page_select  <= page_nxt;
      config_load      <= load_nxt;
      vco_cal_start    <= cal_nxt;
      outputs_released <= rel_nxt;
      straps_as_gpio   <= gpio_nxt;
    end
  end
endmodule : srs_startup_ctrl

/* hdl/srs_params.svh */
// Constants for the start-up, reset and strap controller.
// Assumes a 50 MHz system clock.
`ifndef SRS_PARAMS_SVH
`define SRS_PARAMS_SVH

`define SRS_CLK_PERIOD_NS     20
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define SRS_PD_MIN_PULSE_NS   200
`define SRS_PD_FILT_CYC       (`SRS_PD_MIN_PULSE_NS / `SRS_CLK_PERIOD_NS)
`define SRS_POR_HOLD_CYC      16
`define SRS_CAL_CYC           64
// ------------------------------------------------------------
// Strap encodings
// ------------------------------------------------------------
`define SRS_LVL_LOW           2'h0
`define SRS_LVL_MID           2'h1
`define SRS_LVL_HIGH          2'h2
`define SRS_IF_I2C            1'b0
`define SRS_IF_SPI            1'b1

`endif

/* hdl/srs_pkg.sv */
// Types for the start-up, reset and strap controller.
// Needs no other file.
package srs_pkg;
  typedef enum logic [2:0] {
    SRS_SHUTDOWN,
    SRS_POR_HOLD,
    SRS_STRAP_LATCH,
    SRS_CALIBRATE,
    SRS_RUN
  } srs_state_t;
  typedef logic [1:0] srs_level_t;
endpackage : srs_pkg

/* hdl/srs_strap_if.sv */
// Carries latched strap results from the latch to the sequencer.
// Single clock domain.
interface srs_strap_if;
  logic       interface_spi;
  logic [3:0] rom_page;
  logic       valid;
  modport latch (output interface_spi, output rom_page, output valid);
  modport user  (input interface_spi, input rom_page, input valid);
endinterface : srs_strap_if

/* hdl/srs_strap_latch.sv */
// Strap capture: samples the strap pins once on a capture pulse.
// Pins are synchronous; three-level levels arrive pre-decoded.
`include "srs_params.svh"
module srs_strap_latch (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              capture,
  input  wire logic              interface_select_strap,
  input  wire srs_pkg::srs_level_t rom_page_strap_a,
  input  wire srs_pkg::srs_level_t rom_page_strap_b,
  srs_strap_if.latch             strap
);
  logic       spi_r,  spi_nxt;
  logic [3:0] page_r, page_nxt;
  logic       vld_r,  vld_nxt;

  always_comb begin
    spi_nxt  = spi_r;
    page_nxt = page_r;
    vld_nxt  = vld_r;
    if (capture) begin
      spi_nxt  = interface_select_strap ? `SRS_IF_SPI : `SRS_IF_I2C;
      // Each strap has three levels; the unused code 3 reads as high
      page_nxt = 4'((rom_page_strap_b == 2'h3 ? `SRS_LVL_HIGH : rom_page_strap_b) * 3
                 + (rom_page_strap_a == 2'h3 ? `SRS_LVL_HIGH : rom_page_strap_a));
      vld_nxt  = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      spi_r  <= 1'b0;
      page_r <= 4'h0;
      vld_r  <= 1'b0;
    end else begin
      spi_r  <= spi_nxt;
      page_r <= page_nxt;
      vld_r  <= vld_nxt;
    end
  end

  assign strap.interface_spi = spi_r;
  assign strap.rom_page      = page_r;
  assign strap.valid         = vld_r;
endmodule : srs_strap_latch

/* tb/srs_startup_ctrl_asserts.sv */
// Port checker for the start-up sequencer.
// Bound to srs_startup_ctrl; one clock, synchronous reset.
module srs_chk #(
  parameter int POR_HOLD_CYC = 16,
  parameter int CAL_CYC      = 64
) (
  input wire logic                clk,
  input wire logic                reset_n,
  input wire logic                chip_shutdown_low,
  input wire logic                core_supply_ok,
  input wire logic                shutdown_pin_above_vih,
  input wire logic                interface_select_strap,
  input wire srs_pkg::srs_level_t rom_page_strap_a,
  input wire srs_pkg::srs_level_t rom_page_strap_b,
  input wire logic                soft_reset_bit,
  input wire logic                output_sync_hold_bit,
  input wire logic                device_enable,
  input wire logic                serial_if_enable,
  input wire logic                serial_if_spi,
  input wire logic [3:0]          rom_page_select,
  input wire logic                config_load,
  input wire logic                vco_cal_start,
  input wire logic                outputs_released,
  input wire logic                straps_as_gpio
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Low-pin run length and age of the last calibration
  // ----
  logic [4:0] low_r;
  logic [4:0] low_nxt;
  logic [7:0] age_r;
  logic [7:0] age_nxt;
  always_comb begin
    low_nxt = chip_shutdown_low ? 5'h0 : low_r + {4'h0, ~&low_r};
    age_nxt = vco_cal_start ? 8'h0 : age_r + {7'h0, ~&age_r};
  end
  always_ff @(posedge clk) begin
    low_r <= reset_n ? low_nxt : 5'h0;
    age_r <= reset_n ? age_nxt : 8'h0;
  end
  // Levels 2 and 3 both count as high
  function automatic logic [3:0] pg(input logic [1:0] a, input logic [1:0] b);
    return 4'(3 * (b[1] ? 2 : b) + (a[1] ? 2 : a));
  endfunction : pg
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_pin_rise;
    $rose(chip_shutdown_low) && core_supply_ok && shutdown_pin_above_vih && !device_enable;
  endsequence
  sequence s_soft_run;
    $rose(soft_reset_bit) && device_enable && age_r > CAL_CYC + 2 && low_r == 5'h0;
  endsequence
  a_off_while_low: assert property (low_r > 5'hc |-> !device_enable && !serial_if_enable)
    else $error("device enabled while shut down");
  a_rise_starts_por: assert property (s_pin_rise |-> ##[1:30] vco_cal_start)
    else $error("no start-up after pin rise");
  a_cal_one_pulse: assert property (vco_cal_start |=> !vco_cal_start && device_enable)
    else $error("calibration pulse wrong");
  a_short_low_ignored: assert property (device_enable && low_r < 5'h9 |=> device_enable)
    else $error("short low pulse took effect");
  a_supply_holds_por: assert property ((!core_supply_ok || !shutdown_pin_above_vih) && !serial_if_enable
    |=> !serial_if_enable)
    else $error("start-up without supplies");
  a_spi_from_strap: assert property ($rose(serial_if_enable) |-> serial_if_spi == $past(interface_select_strap))
    else $error("interface choice wrong");
  a_page_from_straps: assert property (config_load |-> rom_page_select == pg($past(rom_page_strap_a),
    $past(rom_page_strap_b)))
    else $error("page choice wrong");
  a_soft_reruns_cal: assert property (s_soft_run |=> vco_cal_start && device_enable && !outputs_released)
    else $error("soft reset did not recalibrate");
  a_straps_kept: assert property (serial_if_enable && $past(serial_if_enable, 3)
    |-> $stable(serial_if_spi) && $stable(rom_page_select))
    else $error("straps changed after start-up");
  a_hold_gates_out: assert property (outputs_released |-> !$past(output_sync_hold_bit) && device_enable)
    else $error("outputs released under hold");
endmodule : srs_chk

bind srs_startup_ctrl srs_chk #(
  .POR_HOLD_CYC (POR_HOLD_CYC),
  .CAL_CYC      (CAL_CYC)
) chk (
  .clk                    (clk),
  .reset_n                (reset_n),
  .chip_shutdown_low      (chip_shutdown_low),
  .core_supply_ok         (core_supply_ok),
  .shutdown_pin_above_vih (shutdown_pin_above_vih),
  .interface_select_strap (interface_select_strap),
  .rom_page_strap_a       (rom_page_strap_a),
  .rom_page_strap_b       (rom_page_strap_b),
  .soft_reset_bit         (soft_reset_bit),
  .output_sync_hold_bit   (output_sync_hold_bit),
  .device_enable          (device_enable),
  .serial_if_enable       (serial_if_enable),
  .serial_if_spi          (serial_if_spi),
  .rom_page_select        (rom_page_select),
  .config_load            (config_load),
  .vco_cal_start          (vco_cal_start),
  .outputs_released       (outputs_released),
  .straps_as_gpio         (straps_as_gpio)
);

/* tb/srs_host.sv */
// Host and power manager model: shutdown pin, supplies, soft reset.
// Clock comes from the bench; the bench calls the tasks.
module srs_host (
  input  wire logic clk,
  output logic      chip_shutdown_low,
  output logic      shutdown_pin_above_vih,
  output logic      core_supply_ok,
  output logic      soft_reset_bit,
  output logic      output_sync_hold_bit
);
  timeunit 1ns;
  timeprecision 1ns;
  // Reference clock taken as valid throughout
  initial begin
    chip_shutdown_low      = 1'b0;
    shutdown_pin_above_vih = 1'b0;
    core_supply_ok         = 1'b0;
    soft_reset_bit         = 1'b0;
    output_sync_hold_bit   = 1'b0;
  end
  // Pin level and its threshold flag move together
  task automatic shut(input int n);
    @(posedge clk);
    chip_shutdown_low      <= 1'b0;
    shutdown_pin_above_vih <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : shut
  // Rails first, then the pin; late only when commanded
  task automatic power_up(input logic late);
    @(posedge clk);
    core_supply_ok <= !late;
    @(posedge clk);
    chip_shutdown_low      <= 1'b1;
    shutdown_pin_above_vih <= 1'b1;
    repeat (8) @(posedge clk);
    core_supply_ok <= 1'b1;
  endtask : power_up
  // Hold set, soft reset pulsed, hold cleared
  task automatic soft_reset();
    repeat (3) @(posedge clk);
    output_sync_hold_bit <= 1'b1;
    @(posedge clk);
    soft_reset_bit <= 1'b1;
    @(posedge clk);
    soft_reset_bit <= 1'b0;
    @(posedge clk);
    output_sync_hold_bit <= 1'b0;
  endtask : soft_reset
endmodule : srs_host

/* tb/srs_startup_ctrl_test.sv */
// Self-checking bench for the start-up sequencer.
// Host model drives pins and supplies; the bench drives straps.
module srs_startup_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset_n, chip_shutdown_low, core_supply_ok, shutdown_pin_above_vih, interface_select_strap;
  logic soft_reset_bit, output_sync_hold_bit, device_enable, serial_if_enable, serial_if_spi, config_load;
  logic vco_cal_start, outputs_released, straps_as_gpio, spi_v;
  srs_pkg::srs_level_t rom_page_strap_a, rom_page_strap_b;
  logic [3:0]          rom_page_select, page_v;
  logic [4:0]          exp_q[$], note, cal_n, exp_cal;
  int                  num_errors, checked, seed;
  // Short counts keep the run brief
  srs_startup_ctrl #(
    .POR_HOLD_CYC (2),
    .CAL_CYC      (4)
  ) DUT (
    .clk                    (clk),
    .reset_n                (reset_n),
    .chip_shutdown_low      (chip_shutdown_low),
    .core_supply_ok         (core_supply_ok),
    .shutdown_pin_above_vih (shutdown_pin_above_vih),
    .interface_select_strap (interface_select_strap),
    .rom_page_strap_a       (rom_page_strap_a),
    .rom_page_strap_b       (rom_page_strap_b),
    .soft_reset_bit         (soft_reset_bit),
    .output_sync_hold_bit   (output_sync_hold_bit),
    .device_enable          (device_enable),
    .serial_if_enable       (serial_if_enable),
    .serial_if_spi          (serial_if_spi),
    .rom_page_select        (rom_page_select),
    .config_load            (config_load),
    .vco_cal_start          (vco_cal_start),
    .outputs_released       (outputs_released),
    .straps_as_gpio         (straps_as_gpio)
  );
  srs_host host (
    .clk                    (clk),
    .chip_shutdown_low      (chip_shutdown_low),
    .shutdown_pin_above_vih (shutdown_pin_above_vih),
    .core_supply_ok         (core_supply_ok),
    .soft_reset_bit         (soft_reset_bit),
    .output_sync_hold_bit   (output_sync_hold_bit)
  );
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    $display("Checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  task automatic wait_rel();
    int n;
    n = 0;
    while (outputs_released !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (outputs_released !== 1'b1) begin
      num_errors++;
      results();
    end
  endtask : wait_rel
  // Each load is matched to the oldest note
  always @(negedge clk) begin
    if (vco_cal_start === 1'b1) cal_n = cal_n + 5'h1;
    if (config_load === 1'b1) begin
      note = (exp_q.size() > 0) ? exp_q.pop_front() : 5'h1f;
      chk({serial_if_spi, rom_page_select}, note);
    end
  end
  initial begin
    reset_n                = 1'b0;
    interface_select_strap = 1'b0;
    rom_page_strap_a       = 2'h0;
    rom_page_strap_b       = 2'h0;
    cal_n                  = 5'h0;
    exp_cal                = 5'h0;
    seed                   = $urandom(32'h0000_573c);
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      spi_v  = 1'($urandom);
      page_v = 4'((i < 9) ? i : 8);
      @(posedge clk);
      interface_select_strap <= spi_v;
      rom_page_strap_a       <= (i < 9) ? 2'(i % 3) : 2'h3;
      rom_page_strap_b       <= (i < 9) ? 2'(i / 3) : 2'h3;
      exp_q.push_back({spi_v, page_v});
      host.shut(14);
      @(negedge clk);
      chk({2'h0, device_enable, serial_if_enable, outputs_released}, 5'h00);
      host.power_up(i == 9);
      wait_rel();
      exp_cal = exp_cal + 5'h1;
      chk(cal_n, exp_cal);
      chk({2'h0, device_enable, serial_if_enable, straps_as_gpio}, 5'h07);
      if (i == 0) begin
        host.shut(5);
        host.power_up(1'b0);
        @(negedge clk);
        chk({2'h0, device_enable, outputs_released, cal_n == exp_cal}, 5'h07);
      end
      @(posedge clk);
      interface_select_strap <= ~spi_v;
      rom_page_strap_a       <= 2'h1;
      host.soft_reset();
      wait_rel();
      exp_cal = exp_cal + 5'h1;
      chk(cal_n, exp_cal);
      chk({serial_if_spi, rom_page_select}, {spi_v, page_v});
      $display("Test %0d done", i);
    end
    chk(5'(exp_q.size()), 5'h00);
    results();
  end
endmodule : srs_startup_ctrl_test
